/* common/dcf_pkg.sv */
// shared constants, types and pointer encodings for the dual-strobe 4x20 buffer
package dcf_pkg;

	// ----------------------------------------
	// geometry
	// ----------------------------------------
	localparam int DCF_DATA_W = 20;
	localparam int DCF_NUM_REGS = 4;
	localparam int DCF_PTR_W = 3;
	localparam int DCF_STAGE_DEPTH = 4;
	localparam int DCF_SYNC_STAGES = 2;

	// ----------------------------------------
	// pointer encodings, bit 0 is Q0
	// ----------------------------------------
	localparam logic [2:0] DCF_PTR_RESET = 3'h0;
	localparam logic [3:0] DCF_SEL_NONE = 4'h0;

	typedef logic [DCF_PTR_W-1:0] dcf_ptr_t;
	typedef logic [DCF_NUM_REGS-1:0] dcf_sel_t;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic strobe;
		logic [DCF_DATA_W-1:0] data;
	} dcf_wr_pins_s;

	typedef struct packed {
		logic full;
		logic empty;
	} dcf_flags_s;

endpackage : dcf_pkg

/* core/dcf_stage_fifo.sv */
// small synchronous staging fifo with valid/ready on both sides
`timescale 1ns/1ps
module dcf_stage_fifo
	import dcf_pkg::*;
#(
	parameter int WIDTH = DCF_DATA_W,
	parameter int DEPTH = DCF_STAGE_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	generate
		if (WIDTH < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
			$error("stage fifo needs width >= 1 and a power-of-two depth >= 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] count_q;
	logic push;
	logic pop;

	assign in_ready = (count_q != (AW+1)'(DEPTH));
	assign out_valid = (count_q != '0);
	assign out_data = mem[rd_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + AW'(1);
			end
			if (pop) begin
				rd_q <= rd_q + AW'(1);
			end
		end
	end

	// occupancy is exact, so full and empty never lie
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			count_q <= '0;
		end else if (push && !pop) begin
			count_q <= count_q + (AW+1)'(1);
		end else if (pop && !push) begin
			count_q <= count_q - (AW+1)'(1);
		end
	end

endmodule : dcf_stage_fifo

/* core/dcf_top.sv */
// dual-strobe 4x20 first-in first-out buffer with gray pointers and two register banks
//
// Operation
// - write strobe rising edge stores write data into the bank register the write pointer selects
// - read strobe rising edge puts the register the read pointer selects on read data
// - words leave in the order written, none reordered; only a word that overflows the staging fifo is skipped
// - at most four 20-bit words are held in the bank at once; the staging fifo holds up to STAGE_DEPTH more
// - input bank loads on write strobe, its 80 bits feed an output bank on read strobe
// - one-hot selects per bank; unselected output-bank registers hold zero
// - read data is a bitwise OR of the four output-bank registers
// - 3-bit write pointer marks next free slot, read pointer marks next to output
// - pointers step Q0Q1Q2 through 000,100,110,010,011,111,101,001 and wrap
// - identical gray-to-one-hot decoders drive the selects of both banks
// - empty is high exactly when both pointers are equal
// - full is high when Q0 matches and Q1, Q2 both differ
// - full goes to the writer and empty to the reader, both active high
// - read edges are dropped while empty and staged writes wait while full; the selects only pick the register
// - all write data inputs and read data outputs are active-high buffered signals
`timescale 1ns/1ps
module dcf_top
	import dcf_pkg::*;
#(
	parameter int DATA_W = DCF_DATA_W,
	parameter int STAGE_DEPTH = DCF_STAGE_DEPTH
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// writer side
	input wire logic WRITE_STROBE,
	input wire logic [DATA_W-1:0] WRITE_DATA,
	output logic FULL,
	// reader side
	input wire logic READ_STROBE,
	output logic [DATA_W-1:0] READ_DATA,
	output logic EMPTY
);

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	generate
		if (DATA_W < 1) begin : g_bad_width
			$error("data width must be at least one bit");
		end
		if (STAGE_DEPTH < 2) begin : g_bad_depth
			$error("staging depth must be at least two words");
		end
		if ((STAGE_DEPTH & (STAGE_DEPTH - 1)) != 0) begin : g_bad_stage
			$error("staging depth must be a power of two");
		end
		// the gray tables below serve exactly four registers and three pointer bits
		if (DCF_NUM_REGS != 4 || DCF_PTR_W != 3) begin : g_bad_geometry
			$error("bank geometry must be four registers with three pointer bits");
		end
	endgenerate

	// ----------------------------------------
	// pointer helpers
	// ----------------------------------------
	// next gray value, bit 0 is Q0
	// Q0 Q1 Q2 walk 000 100 110 010 011 111 101 001, then back to 000
	function automatic dcf_ptr_t gray_next(input dcf_ptr_t p);
		dcf_ptr_t n;
		n = DCF_PTR_RESET;
		case (p)
			3'h0: n = 3'h1;
			3'h1: n = 3'h3;
			3'h3: n = 3'h2;
			3'h2: n = 3'h6;
			3'h6: n = 3'h7;
			3'h7: n = 3'h5;
			3'h5: n = 3'h4;
			3'h4: n = 3'h0;
			default: n = DCF_PTR_RESET;
		endcase
		return n;
	endfunction : gray_next

	// gray value to one-hot register select, shared by both banks
	// positions one to eight land on registers 0 1 2 3 0 1 2 3
	function automatic dcf_sel_t gray_sel(input dcf_ptr_t p);
		dcf_sel_t s;
		s = DCF_SEL_NONE;
		case (p)
			3'h0: s = 4'h1;
			3'h1: s = 4'h2;
			3'h3: s = 4'h4;
			3'h2: s = 4'h8;
			3'h6: s = 4'h1;
			3'h7: s = 4'h2;
			3'h5: s = 4'h4;
			3'h4: s = 4'h8;
			default: s = DCF_SEL_NONE;
		endcase
		return s;
	endfunction : gray_sel

	// pointers four steps apart on the eight-step cycle mean all four registers are taken
	function automatic dcf_flags_s flags_of(input dcf_ptr_t wp, input dcf_ptr_t rp);
		dcf_flags_s f;
		dcf_ptr_t same;
		same = ~(wp ^ rp);
		f.empty = same[0] && same[1] && same[2];
		f.full = same[0] && !same[1] && !same[2];
		return f;
	endfunction : flags_of

	// flags as reset leaves them
	localparam dcf_flags_s FLAGS_AT_RESET = '{full: 1'b0, empty: 1'b1};

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	dcf_wr_pins_s wr_meta_q;
	dcf_wr_pins_s wr_sync_q;
	logic wr_prev_q;
	logic rd_meta_q;
	logic rd_sync_q;
	logic rd_prev_q;
	logic wr_rise;
	logic rd_rise;

	// strobe and data ride the same two stages so they stay aligned
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			wr_meta_q <= '0;
			wr_sync_q <= '0;
		end else begin
			wr_meta_q <= '{strobe: WRITE_STROBE, data: WRITE_DATA};
			wr_sync_q <= wr_meta_q;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			rd_meta_q <= 1'b0;
			rd_sync_q <= 1'b0;
		end else begin
			rd_meta_q <= READ_STROBE;
			rd_sync_q <= rd_meta_q;
		end
	end

	// ----------------------------------------
	// edge detection
	// ----------------------------------------
	// previous levels reset low, matching idle strobes, so release makes no false edge
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			wr_prev_q <= 1'b0;
		end else begin
			wr_prev_q <= wr_sync_q.strobe;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			rd_prev_q <= 1'b0;
		end else begin
			rd_prev_q <= rd_sync_q;
		end
	end

	// edges become one-cycle enables; the strobe never reaches a clock pin
	assign wr_rise = wr_sync_q.strobe & ~wr_prev_q;
	assign rd_rise = rd_sync_q & ~rd_prev_q;

	// ----------------------------------------
	// write staging
	// ----------------------------------------
	logic stage_in_ready;
	logic stage_valid;
	logic [DATA_W-1:0] stage_data;
	logic bank_write;
	dcf_flags_s flags_q;

	// four words of slack for a strobe that crosses a FULL still in flight
	dcf_stage_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(STAGE_DEPTH)
	) u_stage (
		.clk(CLK),
		.reset_n(RESET_N),
		.in_valid(wr_rise),
		.in_data(wr_sync_q.data),
		.in_ready(stage_in_ready),
		.out_valid(stage_valid),
		.out_data(stage_data),
		.out_ready(!flags_q.full)
	);

	// ----------------------------------------
	// pointers and flags
	// ----------------------------------------
	dcf_ptr_t wr_ptr_q;
	dcf_ptr_t wr_ptr_d;
	dcf_ptr_t rd_ptr_q;
	dcf_ptr_t rd_ptr_d;
	dcf_sel_t wr_sel;
	dcf_sel_t rd_sel;
	dcf_flags_s flags_d;
	logic bank_read;

	// a full bank stalls the staging fifo, so no word overwrites unread data
	assign bank_write = stage_valid && !flags_q.full;
	// a read on an empty buffer is dropped rather than wrapping the pointer
	assign bank_read = rd_rise && !flags_q.empty;

	// ----------------------------------------
	// select decoders
	// ----------------------------------------
	// one shared decode, so both banks agree on which register a pointer names
	assign wr_sel = gray_sel(wr_ptr_q);
	assign rd_sel = gray_sel(rd_ptr_q);

	// ----------------------------------------
	// next pointers
	// ----------------------------------------
	always_comb begin
		wr_ptr_d = wr_ptr_q;
		if (bank_write) begin
			wr_ptr_d = gray_next(wr_ptr_q);
		end
	end

	always_comb begin
		rd_ptr_d = rd_ptr_q;
		if (bank_read) begin
			rd_ptr_d = gray_next(rd_ptr_q);
		end
	end

	assign flags_d = flags_of(wr_ptr_d, rd_ptr_d);

	// ----------------------------------------
	// pointer and flag registers
	// ----------------------------------------
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			wr_ptr_q <= DCF_PTR_RESET;
		end else begin
			wr_ptr_q <= wr_ptr_d;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			rd_ptr_q <= DCF_PTR_RESET;
		end else begin
			rd_ptr_q <= rd_ptr_d;
		end
	end

	// flags follow the next pointers so they match the pointer flops exactly
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			flags_q <= FLAGS_AT_RESET;
		end else begin
			flags_q <= flags_d;
		end
	end

	// ----------------------------------------
	// input bank
	// ----------------------------------------
	logic [DATA_W-1:0] in_bank_q [DCF_NUM_REGS];

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			for (int i = 0; i < DCF_NUM_REGS; i++) begin
				in_bank_q[i] <= '0;
			end
		end else if (bank_write) begin
			for (int i = 0; i < DCF_NUM_REGS; i++) begin
				if (wr_sel[i]) begin
					in_bank_q[i] <= stage_data;
				end
			end
		end
	end

	// ----------------------------------------
	// output bank
	// ----------------------------------------
	logic [DATA_W-1:0] out_bank_q [DCF_NUM_REGS];

	// only the selected register loads; the rest clear so the or-tree needs no select
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			for (int i = 0; i < DCF_NUM_REGS; i++) begin
				out_bank_q[i] <= '0;
			end
		end else if (bank_read) begin
			for (int i = 0; i < DCF_NUM_REGS; i++) begin
				out_bank_q[i] <= rd_sel[i] ? in_bank_q[i] : '0;
			end
		end
	end

	// ----------------------------------------
	// output or-tree
	// ----------------------------------------
	logic [DATA_W-1:0] or_tree;

	always_comb begin
		or_tree = '0;
		for (int i = 0; i < DCF_NUM_REGS; i++) begin
			or_tree = or_tree | out_bank_q[i];
		end
	end

	// ----------------------------------------
	// output registers
	// ----------------------------------------
	logic [DATA_W-1:0] read_data_q;

	// one flop behind the or-tree keeps the pins glitch free
	// the extra flop costs one cycle of latency on every read
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			read_data_q <= '0;
		end else begin
			read_data_q <= or_tree;
		end
	end

	assign READ_DATA = read_data_q;
	assign FULL = flags_q.full;
	assign EMPTY = flags_q.empty;

	// ----------------------------------------
	// overflow
	// ----------------------------------------
	// stage_in_ready only falls if the writer ignores FULL; such a word is dropped
	// no pin reports the loss, a limit of the fixed pin list
	logic unused_in_ready;
	assign unused_in_ready = stage_in_ready;

endmodule : dcf_top

/* core/unused_placeholder_none.sv */
// intentionally empty design file list terminator
`timescale 1ns/1ps

/* testbench/dcf_top_properties.sv */
// port checker for the dual-strobe buffer
`timescale 1ns/1ps
module dcf_top_checker
	import dcf_pkg::*;
#(
	parameter int DATA_W = DCF_DATA_W
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// writer side
	input wire logic WRITE_STROBE,
	input wire logic [DATA_W-1:0] WRITE_DATA,
	input wire logic FULL,
	// reader side
	input wire logic READ_STROBE,
	input wire logic [DATA_W-1:0] READ_DATA,
	input wire logic EMPTY
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESET_N);
	// strobes pass two sync flops, so causes sit 3 to 5 edges back
	property p_rst;
		$rose(RESET_N) |-> EMPTY && !FULL && READ_DATA == '0;
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	property p_excl;
		!(FULL && EMPTY);
	endproperty
	a_excl: assert property (p_excl) else $error("full and empty");
	property p_wr_lands;
		$rose(WRITE_STROBE) && EMPTY |-> ##[3:7] !EMPTY;
	endproperty
	a_wr_lands: assert property (p_wr_lands) else $error("word not stored");
	property p_rd_frees;
		$rose(READ_STROBE) && FULL |-> ##[3:7] !FULL;
	endproperty
	a_rd_frees: assert property (p_rd_frees) else $error("full stuck");
	property p_ef_cause;
		$fell(EMPTY) |-> $past(WRITE_STROBE, 4) || $past(WRITE_STROBE, 5);
	endproperty
	a_ef_cause: assert property (p_ef_cause) else $error("empty fell alone");
	property p_fr_cause;
		$rose(FULL) |-> $past(WRITE_STROBE, 4) || $past(WRITE_STROBE, 5);
	endproperty
	a_fr_cause: assert property (p_fr_cause) else $error("full rose alone");
	property p_rel_cause;
		$rose(EMPTY) || $fell(FULL) |-> $past(READ_STROBE, 3) || $past(READ_STROBE, 4) || $past(READ_STROBE, 5);
	endproperty
	a_rel_cause: assert property (p_rel_cause) else $error("flag moved alone");
	property p_rd_cause;
		$changed(READ_DATA) |-> !$past(EMPTY, 3) && ($past(READ_STROBE, 4) || $past(READ_STROBE, 5));
	endproperty
	a_rd_cause: assert property (p_rd_cause) else $error("data moved alone");
	c_full: cover property ($rose(FULL));
	c_drain: cover property ($rose(EMPTY));
	c_data: cover property ($changed(READ_DATA));
endmodule : dcf_top_checker

bind dcf_top dcf_top_checker #(.DATA_W(DATA_W)) chk (.CLK(CLK), .RESET_N(RESET_N), .WRITE_STROBE(WRITE_STROBE),
	.WRITE_DATA(WRITE_DATA), .FULL(FULL), .READ_STROBE(READ_STROBE), .READ_DATA(READ_DATA), .EMPTY(EMPTY));

/* testbench/dcf_link_partner.sv */
// link-side model: writer and reader facing the buffer
`timescale 1ns/1ps
module dcf_link_partner
	import dcf_pkg::*;
#(
	parameter int PERIOD_NS = 800
) (
	// buffer pins
	input wire logic full,
	input wire logic empty,
	output logic wr_strobe,
	output logic [DCF_DATA_W-1:0] wr_data,
	output logic rd_strobe,
	// bench control
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic rd_rude,
	input wire logic [DCF_DATA_W-1:0] wr_word,
	output logic wr_sent,
	output logic rd_sent
);
	// strobes stand still between words
	initial begin
		wr_strobe = 1'b0;
		wr_data = '0;
		wr_sent = 1'b0;
		#937;
		forever begin
			if (wr_en && !full) begin
				wr_data = wr_word;
				#(PERIOD_NS / 4);
				wr_strobe = 1'b1;
				wr_sent = 1'b1;
				#(PERIOD_NS / 2);
				wr_strobe = 1'b0;
				wr_sent = 1'b0;
				// hold time over, stale data must not linger
				wr_data = ~wr_data;
			end
			#(PERIOD_NS / 4);
		end
	end
	initial begin
		rd_strobe = 1'b0;
		rd_sent = 1'b0;
		#1311;
		forever begin
			// rude mode strobes an empty buffer on purpose
			if (rd_rude || (rd_en && !empty)) begin
				rd_sent = !empty;
				#(PERIOD_NS / 4);
				rd_strobe = 1'b1;
				#(PERIOD_NS / 2);
				rd_strobe = 1'b0;
				rd_sent = 1'b0;
			end
			#(PERIOD_NS / 4);
		end
	end
endmodule : dcf_link_partner

/* testbench/dcf_top_bench.sv */
// self-checking bench for the dual-strobe buffer
`timescale 1ns/1ps
module dcf_top_bench
	import dcf_pkg::*;
;
	logic clk;
	logic reset_n = 1'b0;
	logic wr_strobe;
	logic [DCF_DATA_W-1:0] wr_data;
	logic rd_strobe;
	logic [DCF_DATA_W-1:0] rd_data;
	logic full;
	logic empty;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic rd_rude = 1'b0;
	logic wr_sent;
	logic rd_sent;
	logic [15:0] lfsr_q = 16'h8204;
	logic [DCF_DATA_W-1:0] hold_v;
	logic [DCF_DATA_W-1:0] exp_q[$];
	int n_sent = 0;
	int n_fail = 0;
	int num_checks = 0;

	dcf_top dut (.CLK(clk), .RESET_N(reset_n), .WRITE_STROBE(wr_strobe), .WRITE_DATA(wr_data), .FULL(full),
		.READ_STROBE(rd_strobe), .READ_DATA(rd_data), .EMPTY(empty));
	dcf_link_partner link (.full(full), .empty(empty), .wr_strobe(wr_strobe), .wr_data(wr_data),
		.rd_strobe(rd_strobe), .wr_en(wr_en), .rd_en(rd_en), .rd_rude(rd_rude),
		.wr_word({lfsr_q[3:0], lfsr_q}), .wr_sent(wr_sent), .rd_sent(rd_sent));

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next

	task automatic chk_word(input string what, input logic [DCF_DATA_W-1:0] exp, input logic [DCF_DATA_W-1:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_word

	task automatic chk_flag(input string what, input logic exp, input logic got);
		chk_word(what, {19'h0, exp}, {19'h0, got});
	endtask : chk_flag

	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// writer notes each word it hands over
	always @(posedge wr_sent) begin
		exp_q.push_back({lfsr_q[3:0], lfsr_q});
		n_sent++;
		@(posedge clk);
		lfsr_q <= lfsr_next(lfsr_q);
	end

	// data lands six edges after the request; look before the next request can start
	always @(posedge rd_sent) begin
		repeat (7) @(posedge clk);
		chk_word("read data", (exp_q.size() > 0) ? exp_q.pop_front() : 'X, rd_data);
	end

	initial begin
		#400000;
		n_fail++;
		$display("CHECK FAILED watchdog expected done seen hang");
		final_report();
	end

	initial begin
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk);
		chk_flag("empty", 1'b1, empty);
		chk_flag("full", 1'b0, full);
		chk_word("reset data", '0, rd_data);
		wr_en <= 1'b1;
		for (int i = 0; i < 100 && full !== 1'b1; i++) @(posedge clk);
		repeat (20) @(posedge clk);
		chk_word("words held", 20'h4, 20'(n_sent));
		chk_flag("full", 1'b1, full);
		chk_flag("empty", 1'b0, empty);
		wr_en <= 1'b0;
		rd_en <= 1'b1;
		for (int i = 0; i < 100 && empty !== 1'b1; i++) @(posedge clk);
		repeat (20) @(posedge clk);
		chk_flag("full", 1'b0, full);
		hold_v = rd_data;
		rd_rude <= 1'b1;
		for (int i = 0; i < 20 && rd_strobe !== 1'b1; i++) @(posedge clk);
		rd_rude <= 1'b0;
		repeat (12) @(posedge clk);
		chk_word("refused read", hold_v, rd_data);
		chk_flag("empty", 1'b1, empty);
		// random reader stalls let the writer hit full mid-stream
		wr_en <= 1'b1;
		for (int i = 0; i < 400 && n_sent < 52; i++) begin
			repeat (8) @(posedge clk);
			rd_en <= lfsr_q[5] | lfsr_q[9];
		end
		wr_en <= 1'b0;
		rd_en <= 1'b1;
		for (int i = 0; i < 300 && (empty !== 1'b1 || exp_q.size() > 0); i++) @(posedge clk);
		repeat (20) @(posedge clk);
		chk_word("words left", 20'h0, 20'(exp_q.size()));
		final_report();
	end
endmodule : dcf_top_bench
